/* File: common/adc_ctl_consts.vh */
`ifndef ADC_CTL_CONSTS_VH
`define ADC_CTL_CONSTS_VH
// register byte offsets
`define OFS_CONTROL_ONE 12'h000
`define OFS_CONTROL_TWO 12'h004
`define OFS_REGULAR_SEQ 12'h008
`define OFS_INJECTED_SEQ 12'h00c
`define OFS_STATUS 12'h010
`define OFS_REGULAR_RESULT 12'h014
`define OFS_INJECTED_RESULT0 12'h018
`define OFS_INJECTED_OFFSET0 12'h028
`define OFS_SAMPLE 12'h038
// control one fields
`define BIT_SCAN 8
`define BIT_AUTO_INJ 10
`define BIT_REG_DISC 11
`define BIT_INJ_DISC 12
// control two fields
`define BIT_POWER_ON 0
`define BIT_CONTINUOUS 1
`define BIT_ALIGN_LEFT 11
`define POS_INJ_SEL 12
`define BIT_INJ_EXT_EN 15
`define POS_REG_SEL 17
`define BIT_REG_EXT_EN 20
`define BIT_INJ_SW_START 21
`define BIT_REG_SW_START 22
// status fields
`define BIT_DONE 1
`define BIT_INJ_DONE 2
// trigger select codes
`define SEL_SOFTWARE 3'h7
// reset values
`define RESET_WORD 32'h0000_0000
// conversion time
`define CONV_CYCLES 14
`endif

/* File: hw/adc_trigger_align_mode_control.v */
`timescale 1ns/1ns
`include "adc_ctl_consts.vh"
module adc_trigger_align_mode_control
#(
    parameter CONV_CYCLES = `CONV_CYCLES
)
(
    // clock and reset
    input wire core_clk,
    input wire rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // regular trigger sources
    input wire [7:0] regular_trigger_in,
    // injected trigger sources
    input wire [7:0] injected_trigger_in,
    // converter core
    input wire [11:0] conv_data,
    output reg [4:0] conv_channel,
    output reg conv_start,
    output reg regular_busy,
    output reg injected_busy
);
    // control registers
    reg [31:0] control_one;
    reg [31:0] control_two;
    reg [31:0] regular_seq;   // [3:0] length-1, 4-bit channels from bit 4 (7 entries)
    reg [31:0] injected_seq;  // [1:0] length-1, 5-bit channels from bit 2
    reg [1:0] status;
    reg [15:0] regular_result;
    reg [15:0] injected_result [0:3];
    reg [11:0] injected_offset [0:3];
    // trigger synchronisers
    reg [7:0] reg_meta;
    reg [7:0] reg_sync;
    reg [7:0] inj_meta;
    reg [7:0] inj_sync;
    reg reg_prev;
    reg inj_prev;
    reg regular_sw_start;
    reg injected_sw_start;
    // sequencer state
    reg [3:0] reg_index;
    reg [1:0] inj_index;
    reg reg_pending;
    reg inj_pending;
    reg converting;
    reg conv_injected;
    reg [4:0] conv_count;
    integer i;

    wire scan = control_one[`BIT_SCAN];
    wire auto_inj = control_one[`BIT_AUTO_INJ];
    wire continuous_conversion = control_two[`BIT_CONTINUOUS];
    wire power_on = control_two[`BIT_POWER_ON];
    wire align_left = control_two[`BIT_ALIGN_LEFT];
    wire [2:0] reg_sel = control_two[`POS_REG_SEL+2:`POS_REG_SEL];
    wire [2:0] inj_sel = control_two[`POS_INJ_SEL+2:`POS_INJ_SEL];
    wire [3:0] reg_len = scan ? regular_seq[3:0] : 4'h0;
    wire [1:0] inj_len = scan ? injected_seq[1:0] : 2'h0;

    // selected trigger level; code 7 is the software bit
    wire reg_level = (reg_sel == `SEL_SOFTWARE) ? regular_sw_start : reg_sync[reg_sel];
    wire inj_level = (inj_sel == `SEL_SOFTWARE) ? injected_sw_start : inj_sync[inj_sel];
    // rising edge only, gated by group enable
    wire reg_edge = reg_level & ~reg_prev & control_two[`BIT_REG_EXT_EN];
    wire inj_edge = inj_level & ~inj_prev & control_two[`BIT_INJ_EXT_EN];

    wire apb_write = psel & penable & pwrite;
    wire apb_read = psel & ~penable & ~pwrite;
    wire power_rewrite = apb_write && paddr == `OFS_CONTROL_TWO && power_on
        && pwdata[`BIT_POWER_ON];
    wire conv_done = converting && conv_count == 5'h00;

    // channel of a sequence entry
    function [4:0] reg_chan;
        input [31:0] seq;
        input [3:0] idx;
        begin
            reg_chan = {1'b0, seq[4 + idx*4 +: 4]};
        end
    endfunction

    // 16-bit alignment; injected carries the sign
    function [15:0] align;
        input left;
        input injected;
        input [12:0] value;
        begin
            if (!injected)
                align = left ? {value[11:0], 4'h0} : {4'h0, value[11:0]};
            else
                align = left ? {value[12], value[11:0], 3'h0}
                    : {{4{value[12]}}, value[11:0]};
        end
    endfunction

    wire [12:0] inj_diff = {1'b0, conv_data} - {1'b0, injected_offset[inj_index]};

    // trigger sampling: two flops before any logic
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            reg_meta <= 8'h00;
            reg_sync <= 8'h00;
            inj_meta <= 8'h00;
            inj_sync <= 8'h00;
            reg_prev <= 1'b0;
            inj_prev <= 1'b0;
        end
        else
        begin
            reg_meta <= regular_trigger_in;
            reg_sync <= reg_meta;
            inj_meta <= injected_trigger_in;
            inj_sync <= inj_meta;
            reg_prev <= reg_level;
            inj_prev <= inj_level;
        end
    end

    // apb register access, status flags and sequencer
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            control_one <= `RESET_WORD;
            control_two <= `RESET_WORD;
            regular_seq <= `RESET_WORD;
            injected_seq <= `RESET_WORD;
            status <= 2'h0;
            regular_result <= 16'h0000;
            for (i = 0; i < 4; i = i + 1)
            begin
                injected_result[i] <= 16'h0000;
                injected_offset[i] <= 12'h000;
            end
            regular_sw_start <= 1'b0;
            injected_sw_start <= 1'b0;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            reg_index <= 4'h0;
            inj_index <= 2'h0;
            reg_pending <= 1'b0;
            inj_pending <= 1'b0;
            converting <= 1'b0;
            conv_injected <= 1'b0;
            conv_count <= 5'h00;
            conv_channel <= 5'h00;
            conv_start <= 1'b0;
            regular_busy <= 1'b0;
            injected_busy <= 1'b0;
        end
        else
        begin
            // bus: ready one cycle after setup, so access lasts one cycle
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            conv_start <= 1'b0;
            if (apb_read)
            begin
                case (paddr)
                    `OFS_CONTROL_ONE: prdata <= control_one;
                    `OFS_CONTROL_TWO: prdata <= {control_two[31:23], regular_sw_start,
                        injected_sw_start, control_two[20:0]};
                    `OFS_REGULAR_SEQ: prdata <= regular_seq;
                    `OFS_INJECTED_SEQ: prdata <= injected_seq;
                    `OFS_STATUS: prdata <= {29'h0, status, 1'b0};
                    `OFS_REGULAR_RESULT: prdata <= {16'h0, regular_result};
                    default:
                    begin
                        if (paddr >= `OFS_INJECTED_RESULT0 && paddr < `OFS_INJECTED_OFFSET0)
                            prdata <= {16'h0, injected_result[paddr[3:2] + 2'h2]};
                        else if (paddr >= `OFS_INJECTED_OFFSET0 && paddr < `OFS_SAMPLE)
                            prdata <= {20'h0, injected_offset[paddr[3:2] + 2'h2]};
                        else
                            prdata <= 32'h0000_0000;
                    end
                endcase
            end
            if (apb_write)
            begin
                case (paddr)
                    `OFS_CONTROL_ONE: control_one <= pwdata;
                    `OFS_CONTROL_TWO: control_two <= pwdata;
                    `OFS_REGULAR_SEQ: regular_seq <= pwdata;
                    `OFS_INJECTED_SEQ: injected_seq <= pwdata;
                    default:
                    begin
                        if (paddr >= `OFS_INJECTED_OFFSET0 && paddr < `OFS_SAMPLE)
                            injected_offset[paddr[3:2] + 2'h2] <= pwdata[11:0];
                    end
                endcase
            end
            // software start bits set by write, cleared when taken
            if (apb_write && paddr == `OFS_CONTROL_TWO)
            begin
                regular_sw_start <= pwdata[`BIT_REG_SW_START];
                injected_sw_start <= pwdata[`BIT_INJ_SW_START];
            end
            else
            begin
                if (reg_edge)
                    regular_sw_start <= 1'b0;
                if (inj_edge)
                    injected_sw_start <= 1'b0;
            end
            // start requests: busy group ignores its own start
            if ((reg_edge || power_rewrite) && !regular_busy)
                reg_pending <= 1'b1;
            if (inj_edge && !injected_busy && !auto_inj)
                inj_pending <= 1'b1;
            // conversion timing
            if (converting)
                conv_count <= conv_count - 5'h01;
            if (!converting && power_on)
            begin
                // injected first: it may insert into a regular scan
                if (inj_pending)
                begin
                    inj_pending <= 1'b0;
                    injected_busy <= 1'b1;
                    inj_index <= 2'h0;
                    converting <= 1'b1;
                    conv_injected <= 1'b1;
                    conv_channel <= injected_seq[6:2];
                    conv_start <= 1'b1;
                    conv_count <= CONV_CYCLES[4:0] - 5'h01;
                end
                else if (injected_busy)
                begin
                    converting <= 1'b1;
                    conv_injected <= 1'b1;
                    conv_channel <= injected_seq[2 + inj_index*5 +: 5];
                    conv_start <= 1'b1;
                    conv_count <= CONV_CYCLES[4:0] - 5'h01;
                end
                else if (reg_pending || regular_busy)
                begin
                    if (reg_pending)
                        reg_index <= 4'h0;
                    reg_pending <= 1'b0;
                    regular_busy <= 1'b1;
                    converting <= 1'b1;
                    conv_injected <= 1'b0;
                    conv_channel <= reg_chan(regular_seq, reg_pending ? 4'h0 : reg_index);
                    conv_start <= 1'b1;
                    conv_count <= CONV_CYCLES[4:0] - 5'h01;
                end
            end
            // results and flags on completion
            if (conv_done)
            begin
                converting <= 1'b0;
                if (conv_injected)
                begin
                    injected_result[inj_index] <= align(align_left, 1'b1, inj_diff);
                    status <= 2'h3;
                    if (inj_index == inj_len)
                        injected_busy <= 1'b0;
                    else
                        inj_index <= inj_index + 2'h1;
                end
                else
                begin
                    regular_result <= align(align_left, 1'b0, {1'b0, conv_data});
                    status[0] <= 1'b1;
                    if (reg_index == reg_len)
                    begin
                        reg_index <= 4'h0;
                        if (scan && auto_inj)
                        begin
                            inj_pending <= 1'b1;
                            regular_busy <= continuous_conversion;
                        end
                        else
                            regular_busy <= continuous_conversion;
                    end
                    else
                        reg_index <= reg_index + 4'h1;
                end
            end
            // status clear by writing zero; a same-cycle set wins
            if (apb_write && paddr == `OFS_STATUS && !conv_done)
                status <= status & pwdata[2:1];
            // power off aborts everything
            if (!power_on)
            begin
                converting <= 1'b0;
                regular_busy <= 1'b0;
                injected_busy <= 1'b0;
                reg_pending <= 1'b0;
                inj_pending <= 1'b0;
            end
        end
    end
endmodule

/* File: tb/adc_ctl_assertions.sv */
`timescale 1ns/1ns
module adc_ctl_assertions #(parameter CONV_CYCLES = 14) (
    // clock and reset
    input wire core_clk,
    input wire rst,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // trigger sources
    input wire [7:0] regular_trigger_in,
    input wire [7:0] injected_trigger_in,
    // converter core
    input wire [11:0] conv_data,
    input wire [4:0] conv_channel,
    input wire conv_start,
    input wire regular_busy,
    input wire injected_busy
);
    reg [7:0] since_start;
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    // saturating age of the last start, so two starts never overlap a conversion
    always @(posedge core_clk or posedge rst)
    begin
        if (rst)
            since_start <= 8'hff;
        else if (conv_start)
            since_start <= 8'h00;
        else if (since_start != 8'hff)
            since_start <= since_start + 8'h01;
    end
    a_start_pulse: assert property (conv_start |=> !conv_start)
        else $error("start pulse longer than one cycle");
    a_start_spacing: assert property (conv_start |-> since_start >= CONV_CYCLES - 1)
        else $error("start during a running conversion");
    a_busy_on_start: assert property (conv_start |=> (regular_busy || injected_busy))
        else $error("conversion started without busy");
    a_channel_hold: assert property (conv_start |=> ($stable(conv_channel)) [*2])
        else $error("channel moved during conversion");
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_access: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_no_error: assert property (pready |-> !pslverr)
        else $error("error response seen");
    cover property (conv_start && regular_busy);
    cover property (injected_busy && regular_busy);
    cover property (pready && !pwrite);
endmodule

/* File: tb/trigger_source.sv */
`timescale 1ns/1ns
module trigger_source (
    // clock
    input wire core_clk,
    // timer and pin events toward the block
    output reg [7:0] regular_trigger_in = 8'h00,
    output reg [7:0] injected_trigger_in = 8'h00,
    // converter result
    output wire [11:0] conv_data
);
    reg [11:0] sample = 12'h000;
    // held through the whole conversion; the block picks it up at the end
    assign conv_data = sample;
    // an event is a short high level: one rising edge, then a falling one
    task pulse(input bit inj, input [2:0] code);
        @(posedge core_clk);
        if (inj)
            injected_trigger_in[code] <= 1'b1;
        else
            regular_trigger_in[code] <= 1'b1;
        repeat (3) @(posedge core_clk);
        regular_trigger_in <= 8'h00;
        injected_trigger_in <= 8'h00;
    endtask
endmodule

/* File: tb/tb_adc_trigger_align_mode_control.sv */
`timescale 1ns/1ns
module tb_adc_trigger_align_mode_control;
    reg core_clk = 0;
    reg rst = 1;
    reg psel = 0;
    reg penable = 0;
    reg pwrite = 0;
    reg [11:0] paddr = 12'h000;
    reg [31:0] pwdata = 32'h0;
    wire [31:0] prdata;
    wire pready, pslverr, conv_start, regular_busy, injected_busy;
    wire [7:0] regular_trigger_in, injected_trigger_in;
    wire [11:0] conv_data;
    wire [4:0] conv_channel;
    int n_errors = 0, n_tests = 0, n_starts = 0, b, c, k;
    logic [31:0] expq[$];
    logic [12:0] diff;
    logic [11:0] d, off;
    logic [14:0] chans = 15'h0000;
    initial
    begin
        forever #4 core_clk = ~core_clk;
    end
    adc_trigger_align_mode_control #(.CONV_CYCLES(4)) adc_trigger_align_mode_control_i (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .regular_trigger_in(regular_trigger_in), .injected_trigger_in(injected_trigger_in),
        .conv_data(conv_data), .conv_channel(conv_channel), .conv_start(conv_start),
        .regular_busy(regular_busy), .injected_busy(injected_busy));
    trigger_source trigger_source_i (.core_clk(core_clk), .regular_trigger_in(regular_trigger_in),
        .injected_trigger_in(injected_trigger_in), .conv_data(conv_data));
    task finish_test;
        $display("errors %0d of %0d checks", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task check(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input bit w, input [11:0] a, input [31:0] v);
        int j;
        @(posedge core_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= v;
        @(posedge core_clk);
        penable <= 1;
        j = 0;
        do begin @(posedge core_clk); j++; end while (pready !== 1'b1 && j < 50);
        psel <= 0;
        penable <= 0;
        if (pready !== 1'b1)
        begin
            n_errors++;
            finish_test;
        end
    endtask
    task rd(input [11:0] a, input [31:0] e);
        expq.push_back(e);
        apb(0, a, 32'h0);
    endtask
    // a group can chain several conversions, so wait for a quiet stretch, not a fixed time
    task settle(input int base, output int cnt);
        int j, idle;
        idle = 0;
        for (j = 0; j < 400; j++)
        begin
            @(posedge core_clk);
            idle = (regular_busy === 1'b0 && injected_busy === 1'b0) ? idle + 1 : 0;
            if (j >= 40 && idle >= 8)
                break;
        end
        if (j == 400)
        begin
            n_errors++;
            finish_test;
        end
        cnt = n_starts - base;
    endtask
    // count starts and compare each read against the oldest noted value
    always @(posedge core_clk)
    begin
        if (conv_start === 1'b1)
            n_starts <= n_starts + 1;
        // last three channels started, oldest in the top bits
        if (conv_start === 1'b1)
            chans <= {chans[9:0], conv_channel};
        if (psel && penable && pready === 1'b1 && !pwrite)
            check(prdata, expq.pop_front());
    end
    initial
    begin
        void'($urandom(32'h545d));
        repeat (20) @(posedge core_clk);
        rst <= 0;
        b = n_starts; apb(1, 12'h004, 32'h1); settle(b, c); check(c, 0);
        for (k = 0; k < 2; k++)
        begin
            d = $urandom;
            trigger_source_i.sample <= d;
            b = n_starts; apb(1, 12'h004, 32'h1 | k << 11); settle(b, c); check(c, 1);
            rd(12'h014, k ? {16'h0, d, 4'h0} : {20'h0, d});
            rd(12'h010, 32'h2);
            apb(1, 12'h010, 32'h0);
        end
        // continuous rounds restart every CONV_CYCLES+1 cycles; the round
        // running when the bit is cleared is the last one
        b = n_starts;
        apb(1, 12'h004, 32'h3);
        repeat (30) @(posedge core_clk);
        apb(1, 12'h004, 32'h1);
        settle(b, c);
        check(c, 7);
        apb(1, 12'h004, 32'h1); settle(n_starts, c);
        b = n_starts; trigger_source_i.pulse(0, 0); settle(b, c); check(c, 0);
        for (k = 0; k < 7; k++)
        begin
            apb(1, 12'h004, 32'h1 | 1 << 20 | k << 17); settle(n_starts, c);
            b = n_starts; trigger_source_i.pulse(0, (k + 1) % 7); settle(b, c); check(c, 0);
            b = n_starts; trigger_source_i.pulse(0, k); settle(b, c); check(c, 1);
        end
        // software code: the start bit is taken as an edge and reads back clear
        apb(1, 12'h004, 32'h1 | 1 << 20 | 7 << 17 | 1 << 22);
        settle(n_starts, c);
        rd(12'h004, 32'h1 | 1 << 20 | 7 << 17);
        apb(1, 12'h00c, 32'h0);
        for (k = 0; k < 8; k++)
        begin
            off = $urandom;
            d = $urandom;
            diff = {1'b0, d} - {1'b0, off};
            trigger_source_i.sample <= d;
            apb(1, 12'h028, {20'h0, off});
            apb(1, 12'h010, 32'h0);
            apb(1, 12'h004, 32'h1 | 1 << 15 | k << 12 | (k == 3) << 11 | (k == 7) << 21);
            settle(n_starts, c);
            if (k < 7)
            begin
                b = n_starts; trigger_source_i.pulse(1, k); settle(b, c); check(c, 1);
            end
            rd(12'h018, k == 3 ? {16'h0, diff[12], diff[11:0], 3'h0}
                : {16'h0, {4{diff[12]}}, diff[11:0]});
            rd(12'h010, 32'h6);
        end
        // injected enable stays clear while auto injection runs
        apb(1, 12'h004, 32'h1); settle(n_starts, c);
        apb(1, 12'h008, 32'h0000_0a51);
        apb(1, 12'h00c, 32'h0000_004c);
        for (k = 0; k < 3; k++)
        begin
            apb(1, 12'h000, k == 0 ? 32'h0 : k == 1 ? 32'h100 : 32'h500);
            b = n_starts; apb(1, 12'h004, 32'h1); settle(b, c); check(c, k + 1);
        end
        check(chans, {5'h05, 5'h0a, 5'h13});
        apb(1, 12'h000, 32'h100);
        apb(1, 12'h004, 32'h1 | 1 << 15); settle(n_starts, c);
        apb(1, 12'h010, 32'h0);
        b = n_starts; apb(1, 12'h004, 32'h1 | 1 << 15); trigger_source_i.pulse(1, 0);
        settle(b, c); check(c, 3);
        rd(12'h010, 32'h6);
        finish_test;
    end
endmodule
bind adc_trigger_align_mode_control adc_ctl_assertions #(.CONV_CYCLES(CONV_CYCLES)) chk_i (
    .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .regular_trigger_in(regular_trigger_in), .injected_trigger_in(injected_trigger_in),
    .conv_data(conv_data), .conv_channel(conv_channel), .conv_start(conv_start),
    .regular_busy(regular_busy), .injected_busy(injected_busy));
